// ### logic/prog_mem_cfg.svh
/*
 * Constants for the program store and table read path: widths, vectors,
 * reset values and serial programming bit counts.
 * Assumes it is included by bare name from the design and assertion modules.
 */
`ifndef PROG_MEM_CFG_SVH
`define PROG_MEM_CFG_SVH

`define PM_ADDR_W 14
`define PM_DATA_W 16
`define PM_RESET_VEC 14'h0000
`define PM_LAST_PAGE 6'h3F
`define TP_HI_W 6
`define DM_ADDR_W 9
`define DM_SECTOR0 1'h0
`define BYTE_W 8
`define BYTE_ZERO 8'h00
`define WORD_ZERO 16'h0000
`define STAT_W 8
`define STAT_RST 8'h00
`define ICP_CNT_ZERO 5'h00
`define ICP_CNT_ONE 5'h01
`define ICP_ADDR_LAST 5'h0D
`define ICP_DATA_LAST 5'h0F
`define ICP_CMD_WRITE 1'h1

`endif

// ### logic/prog_mem_pkg.sv
/*
 * Types shared by the program store logic and its core-side users.
 * Assumes prog_mem_cfg.svh is on the include path.
 */
`default_nettype none

package prog_mem_pkg;
	// ****************************************
	// types
	// ****************************************
	// one instruction cycle is four non-overlapping phases
	typedef enum logic [1:0] {PH_T1, PH_T2, PH_T3, PH_T4} phase_e;
	// table read forms: short target sector 0, ext any sector
	typedef enum logic [1:0] {TAB_FULL_SHORT, TAB_LAST_SHORT, TAB_FULL_EXT, TAB_LAST_EXT} tab_kind_e;
	// serial programming sequencer
	typedef enum logic [1:0] {ICP_CMD, ICP_ADDR, ICP_DATA, ICP_SEND} icp_e;
endpackage

`default_nettype wire

// ### logic/prog_store.sv
/*
 * Program word store with one registered read port and one write port.
 * Assumes a single clock; array contents are not reset.
 */
`include "prog_mem_cfg.svh"
`default_nettype none

module prog_store #(
	parameter int ADDR_W = `PM_ADDR_W,
	parameter int DATA_W = `PM_DATA_W
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic wr_en,
	input wire logic [DATA_W-1:0] wr_data,
	output logic [DATA_W-1:0] rd_data_ff
);
	// ****************************************
	// storage
	// ****************************************
	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
	logic [DATA_W-1:0] nxt_rd_data;

	// read returns the old word when a write hits the same address
	always_comb
	begin
		nxt_rd_data = mem[addr];
	end

	// array write kept out of the reset process so it can map to ram
	always_ff @(posedge sys_clk)
	begin
		if (wr_en)
		begin
			mem[addr] <= wr_data;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rd_data_ff <= '0;
		end
		else
		begin
			rd_data_ff <= nxt_rd_data;
		end
	end
endmodule

`default_nettype wire

// ### logic/prog_mem_ctrl.sv
/*
 * Program fetch, table read path, table pointers, table high latch,
 * status register update and serial in-circuit programming port.
 * Assumes the core decodes instructions, drives requests from sys_clk
 * logic, and holds icp_mode high only while the programmer owns the pins.
 */
`include "prog_mem_cfg.svh"
`default_nettype none

module prog_mem_ctrl
	import prog_mem_pkg::*;
#(
	parameter int ADDR_W = `PM_ADDR_W,
	parameter int DATA_W = `PM_DATA_W
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic core_pc_load,
	input wire logic [ADDR_W-1:0] core_pc_value,
	input wire logic tab_req,
	input wire tab_kind_e tab_kind,
	input wire logic [`DM_ADDR_W-1:0] tab_operand,
	input wire logic ptr_lo_we,
	input wire logic ptr_hi_we,
	input wire logic [`BYTE_W-1:0] ptr_wr_data,
	input wire logic table_high_latch_we,
	input wire logic [`BYTE_W-1:0] table_high_latch_wr_data,
	input wire logic alu_status_we,
	input wire logic [`STAT_W-1:0] alu_status_in,
	input wire logic icp_mode,
	input wire logic prog_serial_clock_pin,
	input wire logic prog_serial_data_pin_in,
	output logic prog_serial_data_pin_out,
	output logic prog_serial_data_pin_oe,
	output phase_e phase,
	output logic [ADDR_W-1:0] pc,
	output logic [DATA_W-1:0] instr,
	output logic instr_valid,
	output logic tab_busy,
	output logic dm_wr_en,
	output logic [`DM_ADDR_W-1:0] dm_wr_addr,
	output logic [`BYTE_W-1:0] dm_wr_data,
	output logic [`BYTE_W-1:0] table_high_latch,
	output logic [`BYTE_W-1:0] table_ptr_lo,
	output logic [`TP_HI_W-1:0] table_ptr_hi,
	output logic [`STAT_W-1:0] status
);
	// ****************************************
	// declarations
	// ****************************************
	phase_e phase_ff, nxt_phase;
	logic [ADDR_W-1:0] pc_ff, nxt_pc;
	logic tab_busy_ff, nxt_tab_busy;
	tab_kind_e tab_kind_ff, nxt_tab_kind;
	logic [`DM_ADDR_W-1:0] tab_dest_ff, nxt_tab_dest;
	logic [DATA_W-1:0] instr_ff, nxt_instr;
	logic instr_valid_ff, nxt_instr_valid;
	logic dm_wr_en_ff, nxt_dm_wr_en;
	logic [`DM_ADDR_W-1:0] dm_wr_addr_ff, nxt_dm_wr_addr;
	logic [`BYTE_W-1:0] dm_wr_data_ff, nxt_dm_wr_data;
	logic [`BYTE_W-1:0] table_high_latch_ff, nxt_table_high_latch;
	logic [`BYTE_W-1:0] tblp_ff, nxt_tblp;
	logic [`TP_HI_W-1:0] tbhp_ff, nxt_tbhp;
	logic [`STAT_W-1:0] status_ff, nxt_status;
	logic [DATA_W-1:0] store_rd;
	logic [ADDR_W-1:0] store_addr;
	logic [ADDR_W-1:0] tab_addr;
	logic [2:0] ck_sync_ff, dat_sync_ff;
	logic ck_lvl_ff, nxt_ck_lvl, dat_lvl_ff, nxt_dat_lvl;
	logic ck_rise, ck_fall;
	icp_e icp_st_ff, nxt_icp_st;
	logic [4:0] icp_cnt_ff, nxt_icp_cnt;
	logic icp_write_ff, nxt_icp_write;
	logic [ADDR_W-1:0] icp_addr_ff, nxt_icp_addr;
	logic [DATA_W-1:0] icp_shift_ff, nxt_icp_shift;
	logic icp_wr_ff, nxt_icp_wr;
	logic icp_load_ff, nxt_icp_load;
	logic icp_take_ff, nxt_icp_take;
	logic pin_out_ff, nxt_pin_out;

	// ****************************************
	// table address
	// ****************************************
	// last-page forms ignore the high pointer entirely
	function automatic logic [ADDR_W-1:0] tab_address(input tab_kind_e k,
		input logic [`TP_HI_W-1:0] hi, input logic [`BYTE_W-1:0] lo);
		logic [`TP_HI_W-1:0] page;
		page = (k == TAB_LAST_SHORT || k == TAB_LAST_EXT) ? `PM_LAST_PAGE : hi;
		return {page, lo};
	endfunction

	assign tab_addr = tab_address(tab_kind_ff, tbhp_ff, tblp_ff);
	// programmer owns the port in icp mode; table access otherwise wins the fetch slot
	assign store_addr = icp_mode ? icp_addr_ff : (tab_busy_ff ? tab_addr : pc_ff);

	prog_store #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_store (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.addr(store_addr),
		.wr_en(icp_wr_ff),
		.wr_data(icp_shift_ff),
		.rd_data_ff(store_rd)
	);

	// ****************************************
	// phase, fetch and table sequencing
	// ****************************************
	// word addressed at T1 is readable at T2; results are registered at T2 and show at T3
	always_comb
	begin
		nxt_phase = phase_ff;
		nxt_pc = pc_ff;
		nxt_tab_busy = tab_busy_ff;
		nxt_tab_kind = tab_kind_ff;
		nxt_tab_dest = tab_dest_ff;
		nxt_instr = instr_ff;
		nxt_instr_valid = 1'b0;
		nxt_dm_wr_en = 1'b0;
		nxt_dm_wr_addr = dm_wr_addr_ff;
		nxt_dm_wr_data = dm_wr_data_ff;
		case (phase_ff)
			PH_T1: nxt_phase = PH_T2;
			PH_T2: nxt_phase = PH_T3;
			PH_T3: nxt_phase = PH_T4;
			PH_T4: nxt_phase = PH_T1;
			default: nxt_phase = PH_T1;
		endcase
		if (phase_ff == PH_T2)
		begin
			if (tab_busy_ff)
			begin
				nxt_dm_wr_en = 1'b1;
				nxt_dm_wr_data = store_rd[`BYTE_W-1:0];
				nxt_dm_wr_addr = tab_dest_ff;
			end
			else
			begin
				nxt_instr = store_rd;
				nxt_instr_valid = 1'b1;
			end
		end
		if (phase_ff == PH_T4)
		begin
			if (tab_busy_ff)
			begin
				nxt_tab_busy = 1'b0;
			end
			else
			begin
				nxt_pc = core_pc_load ? core_pc_value : pc_ff + 1'b1;
				// request seen at T4 claims the whole next cycle
				nxt_tab_busy = tab_req;
				nxt_tab_kind = tab_kind;
				if (tab_kind == TAB_FULL_SHORT || tab_kind == TAB_LAST_SHORT)
				begin
					nxt_tab_dest = {`DM_SECTOR0, tab_operand[`BYTE_W-1:0]};
				end
				else
				begin
					nxt_tab_dest = tab_operand;
				end
			end
		end
		// programming holds the core at its reset vector
		if (icp_mode)
		begin
			nxt_pc = `PM_RESET_VEC;
			nxt_tab_busy = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			phase_ff <= PH_T1;
			pc_ff <= `PM_RESET_VEC;
			tab_busy_ff <= 1'b0;
			tab_kind_ff <= TAB_FULL_SHORT;
			tab_dest_ff <= '0;
			instr_ff <= `WORD_ZERO;
			instr_valid_ff <= 1'b0;
			dm_wr_en_ff <= 1'b0;
			dm_wr_addr_ff <= '0;
			dm_wr_data_ff <= `BYTE_ZERO;
		end
		else
		begin
			phase_ff <= nxt_phase;
			pc_ff <= nxt_pc;
			tab_busy_ff <= nxt_tab_busy;
			tab_kind_ff <= nxt_tab_kind;
			tab_dest_ff <= nxt_tab_dest;
			instr_ff <= nxt_instr;
			instr_valid_ff <= nxt_instr_valid;
			dm_wr_en_ff <= nxt_dm_wr_en;
			dm_wr_addr_ff <= nxt_dm_wr_addr;
			dm_wr_data_ff <= nxt_dm_wr_data;
		end
	end

	// ****************************************
	// pointers, table high latch, status
	// ****************************************
	// hardware load beats a software write in the same cycle
	always_comb
	begin
		nxt_tblp = ptr_lo_we ? ptr_wr_data : tblp_ff;
		nxt_tbhp = ptr_hi_we ? ptr_wr_data[`TP_HI_W-1:0] : tbhp_ff;
		nxt_table_high_latch = table_high_latch_we ? table_high_latch_wr_data : table_high_latch_ff;
		if (phase_ff == PH_T2 && tab_busy_ff)
		begin
			// store word is exactly two bytes wide, so no bits to zero here
			nxt_table_high_latch = store_rd[DATA_W-1:`BYTE_W];
		end
		nxt_status = alu_status_we ? alu_status_in : status_ff;
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tblp_ff <= `BYTE_ZERO;
			tbhp_ff <= '0;
			table_high_latch_ff <= `BYTE_ZERO;
			status_ff <= `STAT_RST;
		end
		else
		begin
			tblp_ff <= nxt_tblp;
			tbhp_ff <= nxt_tbhp;
			table_high_latch_ff <= nxt_table_high_latch;
			status_ff <= nxt_status;
		end
	end

	// ****************************************
	// programming pin synchronisers
	// ****************************************
	// a level change counts only once stages two and three agree
	always_comb
	begin
		nxt_ck_lvl = (ck_sync_ff[1] == ck_sync_ff[2]) ? ck_sync_ff[2] : ck_lvl_ff;
		nxt_dat_lvl = (dat_sync_ff[1] == dat_sync_ff[2]) ? dat_sync_ff[2] : dat_lvl_ff;
	end

	assign ck_rise = nxt_ck_lvl && !ck_lvl_ff;
	assign ck_fall = !nxt_ck_lvl && ck_lvl_ff;

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ck_sync_ff <= 3'h0;
			dat_sync_ff <= 3'h0;
			ck_lvl_ff <= 1'b0;
			dat_lvl_ff <= 1'b0;
		end
		else
		begin
			ck_sync_ff <= {ck_sync_ff[1:0], prog_serial_clock_pin};
			dat_sync_ff <= {dat_sync_ff[1:0], prog_serial_data_pin_in};
			ck_lvl_ff <= nxt_ck_lvl;
			dat_lvl_ff <= nxt_dat_lvl;
		end
	end

	// ****************************************
	// serial programming sequencer
	// ****************************************
	// frame: command bit, 14 address bits, then 16 data bits in or out, lsb first
	always_comb
	begin
		nxt_icp_st = icp_st_ff;
		nxt_icp_cnt = icp_cnt_ff;
		nxt_icp_write = icp_write_ff;
		nxt_icp_addr = icp_addr_ff;
		nxt_icp_shift = icp_shift_ff;
		nxt_icp_wr = 1'b0;
		nxt_icp_load = 1'b0;
		// store port is registered: the full address is read one clock after it settles
		nxt_icp_take = icp_load_ff;
		nxt_pin_out = pin_out_ff;
		case (icp_st_ff)
			ICP_CMD:
				if (ck_rise)
				begin
					nxt_icp_write = dat_lvl_ff;
					nxt_icp_cnt = `ICP_CNT_ZERO;
					nxt_icp_st = ICP_ADDR;
				end
			ICP_ADDR:
				if (ck_rise)
				begin
					nxt_icp_addr = {dat_lvl_ff, icp_addr_ff[ADDR_W-1:1]};
					nxt_icp_cnt = icp_cnt_ff + `ICP_CNT_ONE;
					if (icp_cnt_ff == `ICP_ADDR_LAST)
					begin
						nxt_icp_cnt = `ICP_CNT_ZERO;
						nxt_icp_st = (icp_write_ff == `ICP_CMD_WRITE) ? ICP_DATA : ICP_SEND;
						nxt_icp_load = (icp_write_ff != `ICP_CMD_WRITE);
					end
				end
			ICP_DATA:
				if (ck_rise)
				begin
					nxt_icp_shift = {dat_lvl_ff, icp_shift_ff[DATA_W-1:1]};
					nxt_icp_cnt = icp_cnt_ff + `ICP_CNT_ONE;
					if (icp_cnt_ff == `ICP_DATA_LAST)
					begin
						nxt_icp_wr = 1'b1;
						nxt_icp_st = ICP_CMD;
					end
				end
			ICP_SEND:
				if (icp_take_ff)
				begin
					nxt_icp_shift = store_rd;
					nxt_pin_out = store_rd[0];
				end
				else if (ck_fall)
				begin
					nxt_icp_shift = {1'b0, icp_shift_ff[DATA_W-1:1]};
					nxt_pin_out = icp_shift_ff[1];
					nxt_icp_cnt = icp_cnt_ff + `ICP_CNT_ONE;
					if (icp_cnt_ff == `ICP_DATA_LAST)
					begin
						nxt_icp_st = ICP_CMD;
					end
				end
			default: nxt_icp_st = ICP_CMD;
		endcase
		// leaving programming mode abandons any half frame
		if (!icp_mode)
		begin
			nxt_icp_st = ICP_CMD;
			nxt_icp_wr = 1'b0;
			nxt_icp_load = 1'b0;
			nxt_icp_take = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			icp_st_ff <= ICP_CMD;
			icp_cnt_ff <= `ICP_CNT_ZERO;
			icp_write_ff <= 1'b0;
			icp_addr_ff <= '0;
			icp_shift_ff <= `WORD_ZERO;
			icp_wr_ff <= 1'b0;
			icp_load_ff <= 1'b0;
			icp_take_ff <= 1'b0;
			pin_out_ff <= 1'b0;
		end
		else
		begin
			icp_st_ff <= nxt_icp_st;
			icp_cnt_ff <= nxt_icp_cnt;
			icp_write_ff <= nxt_icp_write;
			icp_addr_ff <= nxt_icp_addr;
			icp_shift_ff <= nxt_icp_shift;
			icp_wr_ff <= nxt_icp_wr;
			icp_load_ff <= nxt_icp_load;
			icp_take_ff <= nxt_icp_take;
			pin_out_ff <= nxt_pin_out;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign prog_serial_data_pin_out = pin_out_ff;
	assign prog_serial_data_pin_oe = (icp_st_ff == ICP_SEND) && icp_mode;
	assign phase = phase_ff;
	assign pc = pc_ff;
	assign instr = instr_ff;
	assign instr_valid = instr_valid_ff;
	assign tab_busy = tab_busy_ff;
	assign dm_wr_en = dm_wr_en_ff;
	assign dm_wr_addr = dm_wr_addr_ff;
	assign dm_wr_data = dm_wr_data_ff;
	assign table_high_latch = table_high_latch_ff;
	assign table_ptr_lo = tblp_ff;
	assign table_ptr_hi = tbhp_ff;
	assign status = status_ff;
endmodule

`default_nettype wire

// ### tb/prog_serial_host.sv
/*
 * Model of the external programmer on the serial programming pins.
 * Assumes the bench resolves the shared data pin and holds icp_mode high.
 */
`default_nettype none

module prog_serial_host (
	input wire logic sys_clk,
	input wire logic data_in,
	output logic sck,
	output logic sdo
);
	timeunit 1ns;
	timeprecision 100ps;

	// ****************************************
	// pin drivers
	// ****************************************
	// clock rests low between frames
	initial
	begin
		sck = 1'b0;
		sdo = 1'b0;
	end

	// half a serial period, slow enough for the pin filter
	task automatic half();
		repeat (8) @(posedge sys_clk);
	endtask

	// data moves with the fall, device samples on the rise
	task automatic bit_out(input logic b);
		sdo <= b;
		half();
		sck <= 1'b1;
		half();
		sck <= 1'b0;
	endtask

	// frame: command, address lsb first, data lsb first
	task automatic write_word(input logic [13:0] a, input logic [15:0] d);
		bit_out(1'b1);
		for (int i = 0; i < 14; i++)
			bit_out(a[i]);
		for (int i = 0; i < 16; i++)
			bit_out(d[i]);
		half();
	endtask

	// read: device takes the line after the last address rise
	task automatic read_word(input logic [13:0] a, output logic [15:0] d);
		bit_out(1'b0);
		for (int i = 0; i < 13; i++)
			bit_out(a[i]);
		sdo <= a[13];
		half();
		for (int i = 0; i < 16; i++)
		begin
			sck <= 1'b1;
			half();
			d[i] = data_in;
			sck <= 1'b0;
			sdo <= ~sdo; // released: toggle so a stale level cannot pass
			half();
		end
	endtask
endmodule

`default_nettype wire

// ### tb/prog_mem_ctrl_assertions.sv
/*
 * Concurrent checks on fetch, table read and software registers.
 * Assumes it is bound to prog_mem_ctrl and sees only its ports.
 */
`include "prog_mem_cfg.svh"
`default_nettype none

module prog_mem_ctrl_assertions
	import prog_mem_pkg::*;
#(
	parameter int ADDR_W = `PM_ADDR_W
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic core_pc_load,
	input wire logic [ADDR_W-1:0] core_pc_value,
	input wire logic tab_req,
	input wire logic ptr_lo_we,
	input wire logic ptr_hi_we,
	input wire logic [`BYTE_W-1:0] ptr_wr_data,
	input wire logic table_high_latch_we,
	input wire logic [`BYTE_W-1:0] table_high_latch_wr_data,
	input wire logic alu_status_we,
	input wire logic [`STAT_W-1:0] alu_status_in,
	input wire logic icp_mode,
	input wire phase_e phase,
	input wire logic [ADDR_W-1:0] pc,
	input wire logic instr_valid,
	input wire logic tab_busy,
	input wire logic dm_wr_en,
	input wire logic [`BYTE_W-1:0] table_high_latch,
	input wire logic [`BYTE_W-1:0] table_ptr_lo,
	input wire logic [`TP_HI_W-1:0] table_ptr_hi,
	input wire logic [`STAT_W-1:0] status
);
	// ****************************************
	// checks
	// ****************************************
	// programmer owns the store in icp mode, so fetch checks rest then
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!arst_n || icp_mode);

	a_phase_step: assert property (1'b1 |=> phase == $past(phase) + 2'h1)
		else $error("phase did not advance by one");
	a_busy_len: assert property ($rose(tab_busy) |-> tab_busy [*4] ##1 !tab_busy)
		else $error("table cycle not four clocks");
	a_wr_once: assert property ($rose(tab_busy) |-> !dm_wr_en ##1 !dm_wr_en ##1 dm_wr_en ##1 !dm_wr_en)
		else $error("table write not single in third clock");
	a_pc_hold: assert property (tab_busy && $past(tab_busy) |-> $stable(pc))
		else $error("pc moved during table cycle");
	a_pc_step: assert property (phase == PH_T1 && $past(phase) == PH_T4 && !$past(tab_busy)
		&& !$past(core_pc_load) && !$past(icp_mode) |-> pc == $past(pc) + 14'h1)
		else $error("pc did not increment");
	a_pc_load: assert property (phase == PH_T1 && $past(phase) == PH_T4 && !$past(tab_busy)
		&& $past(core_pc_load) && !$past(icp_mode) |-> pc == $past(core_pc_value))
		else $error("pc did not take jump target");
	a_valid_slot: assert property (instr_valid |-> phase == PH_T3 && !tab_busy)
		else $error("fetch result outside its slot");
	a_status_load: assert property (alu_status_we |=> status == $past(alu_status_in))
		else $error("status not loaded");
	a_table_high_latch_write: assert property (table_high_latch_we && !(tab_busy && phase == PH_T2)
		|=> table_high_latch == $past(table_high_latch_wr_data))
		else $error("latch write lost");
	a_ptr_lo: assert property (ptr_lo_we |=> table_ptr_lo == $past(ptr_wr_data))
		else $error("low pointer write lost");
	a_ptr_hi: assert property (ptr_hi_we |=> table_ptr_hi == $past(ptr_wr_data[5:0]))
		else $error("high pointer write lost");

	// main scenarios reached
	c_table: cover property ($rose(tab_busy));
	c_jump: cover property (core_pc_load && phase == PH_T4);
	c_latch: cover property (table_high_latch_we);
endmodule

`default_nettype wire

// ### tb/test_prog_mem_ctrl.sv
/*
 * Self-checking bench for prog_mem_ctrl: programs the store serially,
 * then checks reset fetch, all table forms, software registers and jumps.
 * Assumes the design package and configuration header are compiled first.
 */
`default_nettype none

module test_prog_mem_ctrl
	import prog_mem_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	// ****************************************
	// signals
	// ****************************************
	localparam logic [15:0] W0 = 16'hA55A;
	localparam logic [15:0] W1 = 16'hC3B4;
	localparam logic [15:0] W2 = 16'h7E81;
	localparam logic [15:0] W3 = 16'h001A;
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	logic core_pc_load = 1'b0, tab_req = 1'b0, ptr_lo_we = 1'b0, ptr_hi_we = 1'b0;
	logic table_high_latch_we = 1'b0, alu_status_we = 1'b0, icp_mode = 1'b0;
	logic [13:0] core_pc_value = 14'h0000;
	tab_kind_e tab_kind = TAB_FULL_SHORT;
	logic [8:0] tab_operand = 9'h000;
	logic [7:0] ptr_wr_data = 8'h00, table_high_latch_wr_data = 8'h00, alu_status_in = 8'h00;
	logic sck, host_sdo, pin_out, oe, instr_valid, tab_busy, dm_wr_en;
	wire logic pin_lvl;
	phase_e phase;
	logic [13:0] pc;
	logic [15:0] instr;
	logic [8:0] dm_wr_addr;
	logic [7:0] dm_wr_data, table_high_latch, table_ptr_lo, status;
	logic [5:0] table_ptr_hi;
	int n_fail = 0, n_tests = 0, cyc = 0;

	// shared data pin: whoever enables drives it
	assign pin_lvl = oe ? pin_out : host_sdo;

	prog_mem_ctrl u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .core_pc_load(core_pc_load),
		.core_pc_value(core_pc_value), .tab_req(tab_req), .tab_kind(tab_kind),
		.tab_operand(tab_operand), .ptr_lo_we(ptr_lo_we), .ptr_hi_we(ptr_hi_we),
		.ptr_wr_data(ptr_wr_data), .table_high_latch_we(table_high_latch_we), .table_high_latch_wr_data(table_high_latch_wr_data),
		.alu_status_we(alu_status_we), .alu_status_in(alu_status_in), .icp_mode(icp_mode),
		.prog_serial_clock_pin(sck), .prog_serial_data_pin_in(pin_lvl),
		.prog_serial_data_pin_out(pin_out), .prog_serial_data_pin_oe(oe), .phase(phase),
		.pc(pc), .instr(instr), .instr_valid(instr_valid), .tab_busy(tab_busy),
		.dm_wr_en(dm_wr_en), .dm_wr_addr(dm_wr_addr), .dm_wr_data(dm_wr_data),
		.table_high_latch(table_high_latch), .table_ptr_lo(table_ptr_lo),
		.table_ptr_hi(table_ptr_hi), .status(status));

	prog_serial_host host (.sys_clk(sys_clk), .data_in(pin_lvl), .sck(sck), .sdo(host_sdo));

	// ****************************************
	// helpers
	// ****************************************
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic stop_test();
		$display("tests=%0d fails=%0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic at_phase(input phase_e p);
		do
			@(negedge sys_clk);
		while (phase !== p);
	endtask

	// one table read, judged clock by clock across the busy cycle and one clock after
	task automatic do_table(input tab_kind_e k, input logic [8:0] opd, input logic [15:0] w,
		input logic [8:0] da);
		logic [13:0] pc0;
		at_phase(PH_T3);
		@(posedge sys_clk);
		tab_req <= 1'b1;
		tab_kind <= k;
		tab_operand <= opd;
		@(posedge sys_clk);
		tab_req <= 1'b0;
		for (int i = 1; i <= 5; i++)
		begin
			@(negedge sys_clk);
			if (i == 1)
				pc0 = pc;
			chk(tab_busy, i < 5);
			chk(instr_valid, 1'b0);
			chk(dm_wr_en, i == 3);
			if (i == 4)
				chk(pc, pc0);
		end
		chk(dm_wr_addr, da);
		chk(dm_wr_data, w[7:0]);
		chk(table_high_latch, w[15:8]);
		at_phase(PH_T3);
		chk(instr_valid, 1'b1);
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_program();
		logic [15:0] rd;
		@(posedge sys_clk);
		icp_mode <= 1'b1;
		host.write_word(14'h0000, W0);
		host.write_word(14'h1234, W1);
		host.write_word(14'h1206, W2);
		host.write_word(14'h3F06, W3);
		host.read_word(14'h1234, rd);
		chk(rd, W1);
		@(posedge sys_clk);
		icp_mode <= 1'b0;
	endtask

	// second reset mid-run: fetch restarts at word zero
	task automatic t_reset_fetch();
		@(posedge sys_clk);
		arst_n <= 1'b0;
		@(negedge sys_clk);
		chk(pc, 14'h0000);
		chk(phase, PH_T1);
		@(posedge sys_clk);
		arst_n <= 1'b1;
		@(posedge sys_clk);
		@(negedge sys_clk);
		chk(phase, PH_T2);
		@(negedge sys_clk);
		chk(instr_valid, 1'b1);
		chk(instr, W0);
		chk(pc, 14'h0000);
	endtask

	// high pointer write keeps six bits; last forms ignore it
	task automatic t_table_forms();
		@(posedge sys_clk);
		ptr_lo_we <= 1'b1;
		ptr_wr_data <= 8'h06;
		@(posedge sys_clk);
		ptr_lo_we <= 1'b0;
		ptr_hi_we <= 1'b1;
		ptr_wr_data <= 8'hD2;
		@(posedge sys_clk);
		ptr_hi_we <= 1'b0;
		@(negedge sys_clk);
		chk(table_ptr_lo, 8'h06);
		chk(table_ptr_hi, 6'h12);
		do_table(TAB_FULL_SHORT, 9'h1C5, W2, 9'h0C5);
		do_table(TAB_LAST_SHORT, 9'h1C5, W3, 9'h0C5);
		do_table(TAB_FULL_EXT, 9'h1C5, W2, 9'h1C5);
		do_table(TAB_LAST_EXT, 9'h1C5, W3, 9'h1C5);
	endtask

	// software latch write, then a table read overwrites it
	task automatic t_sw_regs();
		@(posedge sys_clk);
		table_high_latch_we <= 1'b1;
		table_high_latch_wr_data <= 8'hA5;
		alu_status_we <= 1'b1;
		alu_status_in <= 8'h5C;
		ptr_lo_we <= 1'b1;
		ptr_wr_data <= 8'h34;
		@(posedge sys_clk);
		table_high_latch_we <= 1'b0;
		alu_status_we <= 1'b0;
		ptr_lo_we <= 1'b0;
		@(negedge sys_clk);
		chk(table_high_latch, 8'hA5);
		chk(status, 8'h5C);
		do_table(TAB_FULL_SHORT, 9'h020, W1, 9'h020);
	endtask

	task automatic t_jump();
		at_phase(PH_T3);
		@(posedge sys_clk);
		core_pc_load <= 1'b1;
		core_pc_value <= 14'h1234;
		@(posedge sys_clk);
		core_pc_load <= 1'b0;
		at_phase(PH_T3);
		chk(pc, 14'h1234);
		chk(instr, W1);
	endtask

	// ****************************************
	// run control
	// ****************************************
	initial
		forever #2.5 sys_clk = ~sys_clk;

	// run needs about 2600 clocks; the ceiling leaves ample margin
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_fail++;
			stop_test();
		end
	end

	initial
	begin
		repeat (12) @(posedge sys_clk);
		arst_n <= 1'b1;
		t_program();
		t_reset_fetch();
		t_table_forms();
		t_sw_regs();
		t_jump();
		stop_test();
	end
endmodule

bind prog_mem_ctrl prog_mem_ctrl_assertions #(.ADDR_W(ADDR_W)) u_chk (.sys_clk(sys_clk),
	.arst_n(arst_n), .core_pc_load(core_pc_load), .core_pc_value(core_pc_value),
	.tab_req(tab_req), .ptr_lo_we(ptr_lo_we), .ptr_hi_we(ptr_hi_we), .ptr_wr_data(ptr_wr_data),
	.table_high_latch_we(table_high_latch_we), .table_high_latch_wr_data(table_high_latch_wr_data), .alu_status_we(alu_status_we),
	.alu_status_in(alu_status_in), .icp_mode(icp_mode), .phase(phase), .pc(pc),
	.instr_valid(instr_valid), .tab_busy(tab_busy), .dm_wr_en(dm_wr_en),
	.table_high_latch(table_high_latch), .table_ptr_lo(table_ptr_lo),
	.table_ptr_hi(table_ptr_hi), .status(status));

`default_nettype wire
